// *** verilog/timer0_regs.svh ***
// Register offsets, bit positions and reset values of the timer block
`ifndef TIMER0_REGS_SVH
`define TIMER0_REGS_SVH

`define OFS_CNT_LO 6'h12
`define OFS_CMP_A 6'h13
`define OFS_CNT_HI 6'h14
`define OFS_CMP_B 6'h16
`define OFS_FLAGS 6'h38
`define OFS_MASK 6'h39

`define BIT_CMP_A 4
`define BIT_CMP_B 3
`define BIT_OVF 1
`define BIT_CAP 0

`define RST_BYTE 8'h00
`define RST_EV 4'h0
`define MAX_8 8'hFF
`define MAX_16 16'hFFFF

`endif

// *** verilog/timer0_pkg.sv ***
// Types shared by the timer block
package timer0_pkg;
    // Event index inside the four-bit flag and mask vectors
    typedef enum logic [1:0] {
        EV_CAP = 2'h0,
        EV_OVF = 2'h1,
        EV_CMP_B = 2'h2,
        EV_CMP_A = 2'h3
    } event_t;

    typedef struct packed {
        logic [7:0] cnt_lo;
        logic [7:0] cnt_hi;
        logic [7:0] cmp_a;
        logic [7:0] cmp_b;
        logic [7:0] temp;
        logic [7:0] rdata;
        logic [3:0] mask;
        logic [3:0] flags;
        logic block;
    } timer_state_t;
endpackage

// *** verilog/timer0_count_compare_flags.sv ***
// Timer/counter with compare, shared high-byte buffer and event flags
`timescale 1ns/1ps
`include "timer0_regs.svh"

module timer0_count_compare_flags
    import timer0_pkg::*;
#(
    parameter int ADDR_W = 6
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // CPU register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    // Control from the rest of the timer
    input wire logic timer_tick,
    input wire logic width_select,
    input wire logic capture_mode,
    input wire logic capture_is_top,
    input wire logic capture_event,
    // Interrupt controller
    input wire logic global_irq_enable,
    input wire logic [3:0] vector_ack,
    output logic [3:0] irq_request,
    // Status for the output stage
    output logic [3:0] event_set
);

    timer_state_t s_reg;
    timer_state_t s_next;

    logic wr_lo;
    logic wr_hi;
    logic wr_a;
    logic wr_b;
    logic wr_flags;
    logic wr_mask;
    logic rd_lo;
    logic [15:0] count16;
    logic [15:0] compare16;
    logic match_a;
    logic match_b;
    logic at_max;
    logic top_hit;
    logic cap_reg;
    logic cap_take;
    logic [3:0] set_ev;
    logic [3:0] clr_ev;

    // Place the four events at their byte positions
    function automatic logic [7:0] to_byte(input logic [3:0] ev);
        logic [7:0] b;
        b = `RST_BYTE;
        b[`BIT_CMP_A] = ev[EV_CMP_A];
        b[`BIT_CMP_B] = ev[EV_CMP_B];
        b[`BIT_OVF] = ev[EV_OVF];
        b[`BIT_CAP] = ev[EV_CAP];
        return b;
    endfunction

    function automatic logic [3:0] from_byte(input logic [7:0] b);
        logic [3:0] ev;
        ev = `RST_EV;
        ev[EV_CMP_A] = b[`BIT_CMP_A];
        ev[EV_CMP_B] = b[`BIT_CMP_B];
        ev[EV_OVF] = b[`BIT_OVF];
        ev[EV_CAP] = b[`BIT_CAP];
        return ev;
    endfunction

    function automatic logic hit(input logic en, input logic [ADDR_W-1:0] a,
                                 input logic [5:0] ofs);
        return en && (a == ADDR_W'(ofs));
    endfunction

    assign wr_lo = hit(wr_en, addr, `OFS_CNT_LO);
    assign wr_hi = hit(wr_en, addr, `OFS_CNT_HI);
    assign wr_a = hit(wr_en, addr, `OFS_CMP_A);
    assign wr_b = hit(wr_en, addr, `OFS_CMP_B);
    assign wr_flags = hit(wr_en, addr, `OFS_FLAGS);
    assign wr_mask = hit(wr_en, addr, `OFS_MASK);
    assign rd_lo = hit(rd_en, addr, `OFS_CNT_LO);

    assign count16 = {s_reg.cnt_hi, s_reg.cnt_lo};
    assign compare16 = {s_reg.cmp_b, s_reg.cmp_a};

    // Wide mode joins both compare bytes; B then has no match of its own
    assign match_a = width_select ? (count16 == compare16)
                                  : (s_reg.cnt_lo == s_reg.cmp_a);
    assign match_b = !width_select
                     && (s_reg.cnt_lo == s_reg.cmp_b);
    assign at_max = width_select ? (count16 == `MAX_16)
                                 : (s_reg.cnt_lo == `MAX_8);
    assign top_hit = capture_is_top && match_a;
    // Compare A sets no flag of its own in either capture use; it captures the count only in capture_mode with capture_is_top low
    assign cap_reg = capture_mode || capture_is_top;
    assign cap_take = capture_mode && !capture_is_top && capture_event;

    always_comb begin
        set_ev = `RST_EV;
        set_ev[EV_CMP_A] = timer_tick && !s_reg.block && match_a
                           && !cap_reg;
        set_ev[EV_CMP_B] = timer_tick && !s_reg.block
                           && match_b;
        set_ev[EV_OVF] = timer_tick && at_max;
        set_ev[EV_CAP] = cap_take || (timer_tick && top_hit);
    end

    // Write one or vector execution clears; a coincident set still wins
    assign clr_ev = vector_ack
                    | (wr_flags ? from_byte(wdata) : `RST_EV);

    always_comb begin
        s_next = s_reg;
        s_next.flags = (s_reg.flags & ~clr_ev) | set_ev;
        if (timer_tick) begin
            s_next.block = 1'b0;
            if (top_hit) begin
                s_next.cnt_lo = `RST_BYTE;
                if (width_select) begin
                    s_next.cnt_hi = `RST_BYTE;
                end
            end else if (width_select) begin
                {s_next.cnt_hi, s_next.cnt_lo} = count16 + 16'h0001;
            end else begin
                s_next.cnt_lo = s_reg.cnt_lo + 8'h01;
            end
        end
        if (cap_take) begin
            s_next.cmp_a = s_reg.cnt_lo;
            if (width_select) begin
                s_next.cmp_b = s_reg.cnt_hi;
            end
        end
        // Reads: in wide mode a low byte parks its high byte in the shared buffer
        if (rd_en) begin
            case (addr)
                ADDR_W'(`OFS_CNT_LO): begin
                    s_next.rdata = s_reg.cnt_lo;
                    if (width_select) begin
                        s_next.temp = s_reg.cnt_hi;
                    end
                end
                ADDR_W'(`OFS_CNT_HI): begin
                    s_next.rdata = width_select ? s_reg.temp : s_reg.cnt_hi;
                end
                ADDR_W'(`OFS_CMP_A): begin
                    s_next.rdata = s_reg.cmp_a;
                    if (width_select) begin
                        s_next.temp = s_reg.cmp_b;
                    end
                end
                ADDR_W'(`OFS_CMP_B): begin
                    s_next.rdata = width_select ? s_reg.temp : s_reg.cmp_b;
                end
                ADDR_W'(`OFS_FLAGS): begin
                    s_next.rdata = to_byte(s_reg.flags);
                end
                ADDR_W'(`OFS_MASK): begin
                    s_next.rdata = to_byte(s_reg.mask);
                end
                default: begin
                    s_next.rdata = `RST_BYTE;
                end
            endcase
        end
        // CPU writes override counting in the same cycle
        if (wr_lo) begin
            s_next.cnt_lo = wdata;
            s_next.block = 1'b1;
            if (width_select) begin
                s_next.cnt_hi = s_reg.temp;
            end
        end
        if (wr_hi) begin
            if (width_select) begin
                s_next.temp = wdata;
            end else begin
                s_next.cnt_hi = wdata;
            end
        end
        if (wr_a) begin
            s_next.cmp_a = wdata;
            if (width_select) begin
                s_next.cmp_b = s_reg.temp;
            end
        end
        if (wr_b) begin
            if (width_select) begin
                s_next.temp = wdata;
            end else begin
                s_next.cmp_b = wdata;
            end
        end
        if (wr_mask) begin
            s_next.mask = from_byte(wdata);
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata = s_reg.rdata;
    assign event_set = set_ev;
    // Core takes a vector only while enabled, masked in and flagged
    assign irq_request = s_reg.mask & s_reg.flags
                         & {4{global_irq_enable}};

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    sequence blocked_tick;
        s_reg.block && timer_tick;
    endsequence

    sequence wide_low_read;
        rd_lo && width_select && !wr_en;
    endsequence

    // The block bit carries the write over to whichever tick comes next
    block_set_a: assert property (wr_lo |=> s_reg.block)
        else $error("Low write did not arm the block");

    block_tick_a: assert property (blocked_tick
        |=> !$rose(s_reg.flags[EV_CMP_A])
            && !$rose(s_reg.flags[EV_CMP_B]))
        else $error("Compare flag set on blocked tick");

    commit_high_a: assert property (wr_lo && width_select
        |=> s_reg.cnt_hi == $past(s_reg.temp))
        else $error("High byte not taken from buffer");

    latch_temp_a: assert property (wide_low_read
        |=> s_reg.temp == $past(s_reg.cnt_hi))
        else $error("Buffer did not catch high byte");

    irq_gate_a: assert property (irq_request[EV_CMP_A]
        |-> global_irq_enable && s_reg.mask[EV_CMP_A]
            && s_reg.flags[EV_CMP_A])
        else $error("Compare A request without cause");

    b_wide_a: assert property (width_select && $past(width_select)
        |-> !$rose(s_reg.flags[EV_CMP_B]))
        else $error("Compare B flag set in wide mode");

    flag_clear_a: assert property (wr_flags && wdata[`BIT_OVF]
        && !set_ev[EV_OVF] |=> !s_reg.flags[EV_OVF])
        else $error("Overflow flag not cleared by write");

    ovf_set_a: assert property (timer_tick && at_max
        |=> s_reg.flags[EV_OVF] ##1 1'b1)
        else $error("Overflow flag missed");

    ovf_cause_a: assert property ($rose(s_reg.flags[EV_OVF])
        |-> $past(timer_tick) && $past(at_max))
        else $error("Overflow flag without overflow");

    capture_copy_a: assert property (cap_take && !wr_a
        |=> s_reg.cmp_a == $past(s_reg.cnt_lo)
            && s_reg.flags[EV_CAP])
        else $error("Capture did not store count");

    ack_clear_a: assert property (vector_ack[EV_CMP_A]
        && !set_ev[EV_CMP_A] |=> !s_reg.flags[EV_CMP_A])
        else $error("Vector did not clear compare A flag");

    cap_ack_a: assert property (vector_ack[EV_CAP]
        && !set_ev[EV_CAP] |=> !s_reg.flags[EV_CAP])
        else $error("Vector did not clear capture flag");

endmodule // timer0_count_compare_flags

// *** bench/cpu_model.sv ***
// CPU model: byte accesses on the register port, vector acknowledge to the interrupt controller
`timescale 1ns/1ps
module cpu_model (
    // Clock
    input wire logic clock,
    // Register port
    output logic [5:0] addr,
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata,
    // Interrupt controller
    output logic global_irq_enable,
    output logic [3:0] vector_ack
);
    initial begin
        addr = 6'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        wdata = 8'h00;
        global_irq_enable = 1'b0;
        vector_ack = 4'h0;
    end

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(posedge clock);
        #1;
        wr_en = 1'b0;
        // Released bus shows the inverse, not a stale copy
        wdata = ~d;
    endtask

    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clock);
        #1;
        addr = a;
        rd_en = 1'b1;
        @(posedge clock);
        #1;
        rd_en = 1'b0;
        d = rdata;
    endtask

    // High byte first, so the low write commits both bytes at once
    task automatic wr16(input logic [5:0] ah, input logic [5:0] al,
                        input logic [15:0] v);
        wr(ah, v[15:8]);
        wr(al, v[7:0]);
    endtask

    // Lets one edge pass so the gated request has settled on return
    task automatic set_gie(input logic v);
        @(posedge clock);
        #1;
        global_irq_enable = v;
        @(posedge clock);
        #1;
    endtask

    task automatic ack(input logic [3:0] v);
        @(posedge clock);
        #1;
        vector_ack = v;
        @(posedge clock);
        #1;
        vector_ack = 4'h0;
    endtask
endmodule // cpu_model

// *** bench/timer0_count_compare_flags_tb.sv ***
// Self-checking bench for the timer count, compare and flag registers
`timescale 1ns/1ps
`include "timer0_regs.svh"
module timer0_count_compare_flags_tb;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic tick = 1'b0;
    logic wide = 1'b0;
    logic cap_mode = 1'b0;
    logic cap_top = 1'b0;
    logic cap_ev = 1'b0;
    logic [5:0] addr;
    logic wr_en, rd_en, gie;
    logic [7:0] wdata, rdata, rd_v;
    logic [3:0] vack, irq;
    logic [3:0] ev;
    int miscompares = 0;
    int check_count = 0;

    always #10 clock = ~clock;

    cpu_model cpu (
        .clock(clock), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
        .wdata(wdata), .rdata(rdata), .global_irq_enable(gie),
        .vector_ack(vack)
    );
    timer0_count_compare_flags dut (
        .clock(clock), .rst_b(rst_b), .addr(addr), .wr_en(wr_en),
        .rd_en(rd_en), .wdata(wdata), .rdata(rdata), .timer_tick(tick),
        .width_select(wide), .capture_mode(cap_mode),
        .capture_is_top(cap_top), .capture_event(cap_ev),
        .global_irq_enable(gie), .vector_ack(vack), .irq_request(irq),
        .event_set(ev)
    );

    task automatic check(input string n, input logic [7:0] e,
                         input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rchk(input string n, input logic [5:0] a,
                        input logic [7:0] e);
        cpu.rd(a, rd_v);
        check(n, e, rd_v);
    endtask

    // Count is only rewritten between ticks, never under one
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clock);
            #1;
            tick = 1'b1;
            @(posedge clock);
            #1;
            tick = 1'b0;
        end
    endtask

    // One tick; all set strobes but the capture-event one stand only while the tick does
    task automatic tick_ev(input string n, input logic [3:0] e);
        @(posedge clock);
        #1;
        tick = 1'b1;
        #2;
        check(n, {4'h0, e}, {4'h0, ev});
        @(posedge clock);
        #1;
        tick = 1'b0;
    endtask

    task automatic t_reset();
        rchk("cnt_hi", `OFS_CNT_HI, 8'h00);
        rchk("mask", `OFS_MASK, 8'h00);
        rchk("flags", `OFS_FLAGS, 8'h00);
        rchk("unmapped", 6'h3F, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_cmp8();
        cpu.wr(`OFS_CMP_A, 8'h05);
        cpu.wr(`OFS_CMP_B, 8'h06);
        cpu.wr(`OFS_CNT_LO, 8'h05);
        tick_ev("ev blocked", 4'h0);
        tick_ev("ev b", 4'h4);
        rchk("flags b", `OFS_FLAGS, 8'h08);
        cpu.wr(`OFS_MASK, 8'h08);
        check("irq b", 8'h04, {4'h0, irq});
        cpu.wr(`OFS_FLAGS, 8'h08);
        rchk("clr b", `OFS_FLAGS, 8'h00);
        cpu.wr(`OFS_CNT_LO, 8'h04);
        ticks(1);
        tick_ev("ev a", 4'h8);
        rchk("flags a", `OFS_FLAGS, 8'h10);
        check("irq masked", 8'h00, {4'h0, irq});
        cpu.wr(`OFS_MASK, 8'h10);
        check("irq a", 8'h08, {4'h0, irq});
        cpu.ack(4'h8);
        rchk("ack a", `OFS_FLAGS, 8'h00);
        $display("test compare8 done");
    endtask

    task automatic t_wide();
        wide = 1'b1;
        cpu.wr(`OFS_MASK, 8'h00);
        cpu.wr16(`OFS_CMP_B, `OFS_CMP_A, 16'h1300);
        cpu.wr16(`OFS_CNT_HI, `OFS_CNT_LO, 16'h12FF);
        ticks(2);
        rchk("flags 16", `OFS_FLAGS, 8'h10);
        rchk("cnt lo", `OFS_CNT_LO, 8'h01);
        rchk("cnt hi", `OFS_CNT_HI, 8'h13);
        cpu.wr(`OFS_CNT_HI, 8'hAB);
        cpu.wr(`OFS_CMP_A, 8'hCD);
        cpu.wr(`OFS_CNT_LO, 8'h00);
        rchk("cmp lo", `OFS_CMP_A, 8'hCD);
        rchk("cmp hi", `OFS_CMP_B, 8'hAB);
        rchk("shared lo", `OFS_CNT_LO, 8'h00);
        rchk("shared hi", `OFS_CNT_HI, 8'hAB);
        cpu.wr(`OFS_FLAGS, 8'h10);
        cpu.wr(`OFS_MASK, 8'h02);
        cpu.wr16(`OFS_CNT_HI, `OFS_CNT_LO, 16'hFFFF);
        tick_ev("ev ovf", 4'h2);
        check("irq ovf", 8'h02, {4'h0, irq});
        cpu.wr(`OFS_FLAGS, 8'h02);
        rchk("clr ovf", `OFS_FLAGS, 8'h00);
        $display("test wide done");
    endtask

    task automatic t_cap();
        wide = 1'b0;
        cap_mode = 1'b1;
        cpu.wr(`OFS_MASK, 8'h01);
        cpu.wr(`OFS_CNT_LO, 8'h1F);
        ticks(1);
        @(posedge clock);
        #1;
        cap_ev = 1'b1;
        @(posedge clock);
        #1;
        cap_ev = 1'b0;
        ticks(1);
        rchk("cap flags", `OFS_FLAGS, 8'h01);
        rchk("cap value", `OFS_CMP_A, 8'h20);
        check("irq cap", 8'h01, {4'h0, irq});
        cpu.set_gie(1'b0);
        check("irq gie", 8'h00, {4'h0, irq});
        cpu.set_gie(1'b1);
        cpu.ack(4'h1);
        rchk("cap ack", `OFS_FLAGS, 8'h00);
        cap_mode = 1'b0;
        cap_top = 1'b1;
        cpu.wr(`OFS_CNT_LO, 8'h1F);
        ticks(2);
        rchk("top flag", `OFS_FLAGS, 8'h01);
        cpu.wr(`OFS_FLAGS, 8'h01);
        rchk("top clr", `OFS_FLAGS, 8'h00);
        $display("test capture done");
    endtask

    // Dirty count, mask and flag registers, then reset in mid-run
    task automatic t_rst_mid();
        cap_top = 1'b0;
        cpu.wr(`OFS_CNT_HI, 8'h5A);
        cpu.wr(`OFS_MASK, 8'hFF);
        rchk("mask bits", `OFS_MASK, 8'h1B);
        cpu.wr(`OFS_CNT_LO, 8'hFF);
        ticks(1);
        rchk("ovf 8", `OFS_FLAGS, 8'h02);
        @(posedge clock);
        #1;
        rst_b = 1'b0;
        @(posedge clock);
        #1;
        rst_b = 1'b1;
        t_reset();
        $display("test mid reset done");
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clock);
        #1;
        rst_b = 1'b1;
        cpu.set_gie(1'b1);
        t_reset();
        t_cmp8();
        t_wide();
        t_cap();
        t_rst_mid();
        close_out();
    end

    // Hang guard
    initial begin
        #1000000;
        miscompares++;
        close_out();
    end
endmodule // timer0_count_compare_flags_tb
